//--- hdl/ippc_irq_state.v
// One interrupt's state machine: inactive, pending, active, active-and-pending.
// Assumes a request line already synchronised to sys_clk_i and one-cycle event strobes.
`timescale 1ns/1ps
`include "ippc_map.vh"

module ippc_irq_state (
	input  wire clk_i,
	input  wire rst_n_i,
	input  wire level_mode_i,
	input  wire line_i,
	input  wire line_prev_i,
	input  wire sw_set_i,
	input  wire sw_clr_i,
	input  wire enter_i,
	input  wire exit_i,
	output wire pending_o,
	output wire active_o
);
	localparam [3:0] ST_INACTIVE = `IPPC_ST_INACTIVE;
	localparam [3:0] ST_PENDING  = `IPPC_ST_PENDING;
	localparam [3:0] ST_ACTIVE   = `IPPC_ST_ACTIVE;
	localparam [3:0] ST_ACT_PEND = `IPPC_ST_ACT_PEND;

	reg  [3:0] state_reg;
	reg  [3:0] state_next;
	wire       rise;
	wire       hw_req;

	assign rise   = line_i & ~line_prev_i;
	// A level line requests while high; a pulse line requests on each rising edge.
	assign hw_req = level_mode_i ? line_i : rise;

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_INACTIVE: begin
				if (hw_req | sw_set_i)
					state_next = ST_PENDING;
			end
			ST_PENDING: begin
				if (enter_i)
					state_next = ST_ACTIVE;
				// A request seen in the same cycle as a clear wins, so no edge is lost.
				else if (sw_clr_i & ~sw_set_i & ~hw_req)
					state_next = ST_INACTIVE;
			end
			ST_ACTIVE: begin
				if (exit_i) begin
					if ((level_mode_i & line_i) | sw_set_i | (~level_mode_i & rise))
						state_next = ST_PENDING;
					else
						state_next = ST_INACTIVE;
				end else if (sw_set_i | (~level_mode_i & rise))
					state_next = ST_ACT_PEND;
			end
			ST_ACT_PEND: begin
				if (exit_i)
					state_next = ST_PENDING;
				else if (sw_clr_i & ~sw_set_i & ~hw_req)
					state_next = ST_ACTIVE;
			end
			default: begin
				state_next = ST_INACTIVE;
			end
		endcase
	end

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			state_reg <= ST_INACTIVE;
		else
			state_reg <= state_next;
	end

	assign pending_o = (state_reg == ST_PENDING) | (state_reg == ST_ACT_PEND);
	assign active_o  = (state_reg == ST_ACTIVE) | (state_reg == ST_ACT_PEND);
endmodule // ippc_irq_state

//--- hdl/ippc_map.vh
// Register map, field layout and state codes of the interrupt priority and pending controller.
// Included by the state machine and top design files and by the port checker; holds definitions only.
`ifndef IPPC_MAP_VH
`define IPPC_MAP_VH

`define IPPC_ADDR_W        12
`define IPPC_OFS_EN_SET    12'h100
`define IPPC_OFS_EN_CLR    12'h180
`define IPPC_OFS_PEND_SET  12'h200
`define IPPC_OFS_PEND_CLR  12'h280
`define IPPC_OFS_PRIO_LO   12'h400
`define IPPC_OFS_PRIO_HI   12'h41c
`define IPPC_OFS_ACTIVE    12'h300
`define IPPC_OFS_CPU       12'h304
`define IPPC_PRIO_IDX_LSB  2
`define IPPC_PRIO_IDX_MSB  4
`define IPPC_PRIO_MSB      7
`define IPPC_PRIO_LSB      6
`define IPPC_BYTE_W        8
`define IPPC_ZERO32        32'h00000000
`define IPPC_ZERO2         2'h0
`define IPPC_NONE_IRQ      6'h3f
`define IPPC_ST_INACTIVE   4'h1
`define IPPC_ST_PENDING    4'h2
`define IPPC_ST_ACTIVE     4'h4
`define IPPC_ST_ACT_PEND   4'h8

`endif

//--- hdl/ippc_sync2.v
// Two-flop synchroniser for one asynchronous level.
// Assumes the destination clock and reset given at its ports.
`timescale 1ns/1ps

module ippc_sync2 (
	input  wire clk_i,
	input  wire rst_n_i,
	input  wire d_i,
	output wire q_o
);
	reg meta_reg;
	reg sync_reg;

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= d_i;
			sync_reg <= meta_reg;
		end
	end

	assign q_o = sync_reg;
endmodule // ippc_sync2

//--- hdl/ippc_top.v
// Interrupt priority and pending controller: enables, pending/active states, priorities, APB.
// Assumes one 50 MHz clock, request lines from outside the domain and a core giving
// one-cycle service-entry and service-exit strobes for the granted interrupt number.
//
// Function
// - One 2-bit priority per interrupt, eight words.
// - Priority words accessed as full words only.
// - Smaller priority value is more urgent.
// - Only field bits 7:6 stored; rest zero.
// - Word M/4, byte lane M mod 4.
// - Sample request lines on clock; latch as pending.
// - Pending by level, rising edge, or software.
// - Service entry turns pending into active.
// - Level exit: re-pend if line high, else inactive.
// - Pulse during service: active-pending, then pending.
// - No pulse during service: inactive on exit.
// - Level clear-pending ignored while line high.
// - Pulse clear: pending->inactive, active-pending->active.
// - Disabled interrupts still become pending.
// - Only enabled pending interrupts are offered.
// - Clear-pending never touches active state.
// - Enable set/clear writes ones; reads enables.
`timescale 1ns/1ps
`include "ippc_map.vh"

module ippc_top #(
	parameter NUM_IRQ = 32
) (
	input  wire                        sys_clk_i,
	input  wire                        nrst_i,
	input  wire [NUM_IRQ-1:0]          irq_line_i,
	input  wire [NUM_IRQ-1:0]          irq_level_i,
	input  wire                        isr_enter_i,
	input  wire                        isr_exit_i,
	input  wire [5:0]                  isr_num_i,
	input  wire                        psel_i,
	input  wire                        penable_i,
	input  wire                        pwrite_i,
	input  wire [`IPPC_ADDR_W-1:0]     paddr_i,
	input  wire [31:0]                 pwdata_i,
	output reg  [31:0]                 prdata_o,
	output wire                        pready_o,
	output reg                         pslverr_o,
	output reg                         irq_req_o,
	output reg  [5:0]                  irq_num_o,
	output reg  [1:0]                  irq_prio_o
);
	// ==========================================================================
	// Reset release
	// ==========================================================================
	reg rst_meta_reg;
	reg rst_n_reg;

	always @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	// ==========================================================================
	// Request line sampling
	// ==========================================================================
	wire [NUM_IRQ-1:0] line_sync;
	reg  [NUM_IRQ-1:0] line_prev_reg;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_IRQ; gi = gi + 1) begin : g_sync
			ippc_sync2 u_sync (
				.clk_i   (sys_clk_i),
				.rst_n_i (rst_n_reg),
				.d_i     (irq_line_i[gi]),
				.q_o     (line_sync[gi])
			);
		end
	endgenerate

	always @(posedge sys_clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg)
			line_prev_reg <= {NUM_IRQ{1'b0}};
		else
			line_prev_reg <= line_sync;
	end

	// ==========================================================================
	// APB decode
	// ==========================================================================
	// The slave never inserts wait states, so an access completes in its first access cycle.
	// Ready comes from a flop that rises once reset has been released.
	reg pready_reg;

	always @(posedge sys_clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg)
			pready_reg <= 1'b0;
		else
			pready_reg <= 1'b1;
	end

	assign pready_o = pready_reg;

	wire       wr_stb;
	wire       rd_stb;
	wire       hit_prio;
	wire [2:0] prio_idx;

	assign wr_stb   = psel_i & penable_i & pwrite_i;
	assign rd_stb   = psel_i & ~penable_i & ~pwrite_i;
	assign hit_prio = (paddr_i >= `IPPC_OFS_PRIO_LO) && (paddr_i <= `IPPC_OFS_PRIO_HI);
	assign prio_idx = paddr_i[`IPPC_PRIO_IDX_MSB:`IPPC_PRIO_IDX_LSB];

	// APB carries whole words only, so sub-word priority access cannot arise.
	// Low address bits are ignored only in the priority range up to 12'h41c; software keeps accesses aligned.
	reg [NUM_IRQ-1:0] en_set;
	reg [NUM_IRQ-1:0] en_clr;
	reg [NUM_IRQ-1:0] pend_set;
	reg [NUM_IRQ-1:0] pend_clr;
	reg               prio_wr;
	reg               addr_ok;

	always @* begin
		en_set   = {NUM_IRQ{1'b0}};
		en_clr   = {NUM_IRQ{1'b0}};
		pend_set = {NUM_IRQ{1'b0}};
		pend_clr = {NUM_IRQ{1'b0}};
		prio_wr  = 1'b0;
		addr_ok  = 1'b1;
		if (paddr_i == `IPPC_OFS_EN_SET) begin
			en_set = pwdata_i[NUM_IRQ-1:0] & {NUM_IRQ{wr_stb}};
		end else if (paddr_i == `IPPC_OFS_EN_CLR) begin
			en_clr = pwdata_i[NUM_IRQ-1:0] & {NUM_IRQ{wr_stb}};
		end else if (paddr_i == `IPPC_OFS_PEND_SET) begin
			pend_set = pwdata_i[NUM_IRQ-1:0] & {NUM_IRQ{wr_stb}};
		end else if (paddr_i == `IPPC_OFS_PEND_CLR) begin
			pend_clr = pwdata_i[NUM_IRQ-1:0] & {NUM_IRQ{wr_stb}};
		end else if (hit_prio) begin
			prio_wr = wr_stb;
		end else if (paddr_i == `IPPC_OFS_ACTIVE) begin
			addr_ok = ~pwrite_i;
		end else if (paddr_i == `IPPC_OFS_CPU) begin
			addr_ok = ~pwrite_i;
		end else begin
			addr_ok = 1'b0;
		end
	end

	// ==========================================================================
	// Enables and priorities
	// ==========================================================================
	reg [NUM_IRQ-1:0] enable_reg;
	reg [1:0]         prio_reg [0:NUM_IRQ-1];
	integer           k;

	always @(posedge sys_clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg)
			enable_reg <= {NUM_IRQ{1'b0}};
		else
			enable_reg <= (enable_reg | en_set) & ~en_clr;
	end

	always @(posedge sys_clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			for (k = 0; k < NUM_IRQ; k = k + 1)
				prio_reg[k] <= `IPPC_ZERO2;
		end else if (prio_wr) begin
			for (k = 0; k < NUM_IRQ; k = k + 1) begin
				if ((k / 4) == prio_idx)
					prio_reg[k] <= pwdata_i[(k % 4) * `IPPC_BYTE_W + `IPPC_PRIO_LSB +: 2];
			end
		end
	end

	// ==========================================================================
	// Per-interrupt state
	// ==========================================================================
	wire [NUM_IRQ-1:0] pending;
	wire [NUM_IRQ-1:0] active;

	generate
		for (gi = 0; gi < NUM_IRQ; gi = gi + 1) begin : g_state
			ippc_irq_state u_state (
				.clk_i        (sys_clk_i),
				.rst_n_i      (rst_n_reg),
				.level_mode_i (irq_level_i[gi]),
				.line_i       (line_sync[gi]),
				.line_prev_i  (line_prev_reg[gi]),
				.sw_set_i     (pend_set[gi]),
				.sw_clr_i     (pend_clr[gi]),
				.enter_i      (isr_enter_i & (isr_num_i == gi)),
				.exit_i       (isr_exit_i & (isr_num_i == gi)),
				.pending_o    (pending[gi]),
				.active_o     (active[gi])
			);
		end
	endgenerate

	// ==========================================================================
	// Arbitration
	// ==========================================================================
	wire [NUM_IRQ-1:0] cand;
	reg                best_any;
	reg  [5:0]         best_num;
	reg  [1:0]         best_prio;
	integer            j;

	assign cand = pending & enable_reg;

	// Strict less-than while scanning upward keeps the lowest number on a tie.
	always @* begin
		best_any  = 1'b0;
		best_num  = `IPPC_NONE_IRQ;
		best_prio = `IPPC_ZERO2;
		for (j = 0; j < NUM_IRQ; j = j + 1) begin
			if (cand[j] && (!best_any || (prio_reg[j] < best_prio))) begin
				best_any  = 1'b1;
				best_num  = j[5:0];
				best_prio = prio_reg[j];
			end
		end
	end

	always @(posedge sys_clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			irq_req_o  <= 1'b0;
			irq_num_o  <= `IPPC_NONE_IRQ;
			irq_prio_o <= `IPPC_ZERO2;
		end else begin
			irq_req_o  <= best_any;
			irq_num_o  <= best_num;
			irq_prio_o <= best_prio;
		end
	end

	// ==========================================================================
	// Read data
	// ==========================================================================
	reg [31:0] rd_word;
	integer    m;

	always @* begin
		rd_word = `IPPC_ZERO32;
		if ((paddr_i == `IPPC_OFS_EN_SET) || (paddr_i == `IPPC_OFS_EN_CLR)) begin
			rd_word[NUM_IRQ-1:0] = enable_reg;
		end else if ((paddr_i == `IPPC_OFS_PEND_SET) || (paddr_i == `IPPC_OFS_PEND_CLR)) begin
			rd_word[NUM_IRQ-1:0] = pending;
		end else if (hit_prio) begin
			for (m = 0; m < NUM_IRQ; m = m + 1) begin
				if ((m / 4) == prio_idx)
					rd_word[(m % 4) * `IPPC_BYTE_W + `IPPC_PRIO_LSB +: 2] = prio_reg[m];
			end
		end else if (paddr_i == `IPPC_OFS_ACTIVE) begin
			rd_word[NUM_IRQ-1:0] = active;
		end else if (paddr_i == `IPPC_OFS_CPU) begin
			rd_word = {23'h000000, irq_req_o, irq_prio_o, irq_num_o};
		end
	end

	// Read data is captured at the end of the setup cycle, so it stands through the
	// access cycle and the master takes it at the edge where it sees ready.
	always @(posedge sys_clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			prdata_o  <= `IPPC_ZERO32;
			pslverr_o <= 1'b0;
		end else begin
			if (rd_stb)
				prdata_o <= rd_word;
			pslverr_o <= psel_i & ~penable_i & ~addr_ok;
		end
	end
endmodule // ippc_top

//--- testbench/ippc_core_model.sv
// Core model: one-cycle service-entry and service-exit strobes.
// Assumes the controller samples them on the rising clock edge.
`timescale 1ns/1ps
module ippc_core_model (
	input  wire       clk_i,
	output reg        enter_o = 1'h0,
	output reg        exit_o = 1'h0,
	output reg  [5:0] num_o = 6'h0
);
	// A strobe held longer would enter or leave the routine twice.
	task automatic strobe(input bit ent, input [5:0] n);
		@(posedge clk_i);
		enter_o <= ent;
		exit_o <= !ent;
		num_o <= n;
		@(posedge clk_i);
		enter_o <= 1'h0;
		exit_o <= 1'h0;
	endtask
endmodule // ippc_core_model

//--- testbench/ippc_top_props.sv
// Port checker of the interrupt priority and pending controller.
// Assumes one clock domain and nrst_i as the reset seen at the top.
`timescale 1ns/1ps
`include "ippc_map.vh"
module ippc_top_props #(
	parameter NUM_IRQ = 32
) (
	input wire        sys_clk_i,
	input wire        nrst_i,
	input wire        psel_i,
	input wire        penable_i,
	input wire        pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	input wire [31:0] prdata_o,
	input wire        pslverr_o,
	input wire        irq_req_o,
	input wire [5:0]  irq_num_o,
	input wire [1:0]  irq_prio_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	// ====================
	// Enable mirror; the delayed copy matches the registered request outputs.
	logic [NUM_IRQ-1:0] en_reg, en_dly_reg;
	wire acc_w = psel_i && penable_i && pwrite_i;
	wire rd_acc = psel_i && penable_i && !pwrite_i;
	wire [11:0] word_a = {paddr_i[11:2], 2'h0};
	wire prio_acc = psel_i && penable_i && word_a >= `IPPC_OFS_PRIO_LO && word_a <= `IPPC_OFS_PRIO_HI;
	always @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			en_reg <= '0;
			en_dly_reg <= '0;
		end else begin
			en_dly_reg <= en_reg;
			if (acc_w && word_a == `IPPC_OFS_EN_SET)
				en_reg <= en_reg | pwdata_i[NUM_IRQ-1:0];
			else if (acc_w && word_a == `IPPC_OFS_EN_CLR)
				en_reg <= en_reg & ~pwdata_i[NUM_IRQ-1:0];
		end
	end
	// ====================
	// Properties
	property p_reset_idle; $rose(nrst_i) |-> !irq_req_o && irq_num_o == 6'h3f && irq_prio_o == 2'h0; endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
	property p_none_code; !irq_req_o |-> irq_num_o == 6'h3f && irq_prio_o == 2'h0; endproperty
	a_none_code: assert property (p_none_code) else $error("idle code wrong");
	property p_winner_range; irq_req_o |-> irq_num_o < NUM_IRQ; endproperty
	a_winner_range: assert property (p_winner_range) else $error("winner out of range");
	property p_req_enabled; irq_req_o |-> en_dly_reg[irq_num_o[4:0]]; endproperty
	a_req_enabled: assert property (p_req_enabled) else $error("disabled winner");
	property p_dis_all; acc_w && word_a == `IPPC_OFS_EN_CLR && pwdata_i == 32'hffffffff
		|-> ##2 !irq_req_o [*2]; endproperty
	a_dis_all: assert property (p_dis_all) else $error("request after disable");
	property p_en_read; rd_acc && (word_a == `IPPC_OFS_EN_SET || word_a == `IPPC_OFS_EN_CLR)
		|-> prdata_o[NUM_IRQ-1:0] == en_dly_reg; endproperty
	a_en_read: assert property (p_en_read) else $error("enable read wrong");
	property p_prio_low_zero; rd_acc && prio_acc |-> (prdata_o & 32'h3f3f3f3f) == 32'h0; endproperty
	a_prio_low_zero: assert property (p_prio_low_zero) else $error("low field bits set");
	property p_prio_word_ok; prio_acc |-> !pslverr_o; endproperty
	a_prio_word_ok: assert property (p_prio_word_ok) else $error("word access refused");
endmodule // ippc_top_props
bind ippc_top ippc_top_props #(.NUM_IRQ(NUM_IRQ)) i_ippc_top_props (.sys_clk_i, .nrst_i, .psel_i,
	.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pslverr_o, .irq_req_o, .irq_num_o,
	.irq_prio_o);

//--- testbench/test_interrupt_priority_pending_ctrl.sv
// Self-checking bench of the interrupt priority and pending controller.
// Assumes the design under hdl/, the core model and the bound checker.
`timescale 1ns/1ps
module test_interrupt_priority_pending_ctrl;
	typedef struct {bit wr; logic [11:0] a; logic [31:0] d, ex; bit er;} ippc_row_t;
	logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, line = 32'h0, lvl = 32'h20, rdat;
	wire [31:0] prdata;
	wire pready, pslverr, req, ent, ext;
	wire [5:0] num, inum;
	wire [1:0] prio;
	int num_errors = 0, samples_checked = 0;
	ippc_row_t rows[6] = '{
		'{1'h1, 12'h400, 32'hffffffff, 32'hc0c0c0c0, 1'h0},
		'{1'h1, 12'h41c, 32'h40c08000, 32'h40c08000, 1'h0},
		'{1'h1, 12'h100, 32'h0000000f, 32'h0000000f, 1'h0},
		'{1'h1, 12'h180, 32'h00000003, 32'h0000000c, 1'h0},
		'{1'h1, 12'h100, 32'h00000000, 32'h0000000c, 1'h0},
		'{1'h1, 12'h000, 32'hffffffff, 32'h00000000, 1'h1}};
	always #10 clk = ~clk;
	ippc_top #(.NUM_IRQ(32)) i_ippc_top (.sys_clk_i(clk), .nrst_i(nrst), .irq_line_i(line),
		.irq_level_i(lvl), .isr_enter_i(ent), .isr_exit_i(ext), .isr_num_i(inum),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.irq_req_o(req), .irq_num_o(num), .irq_prio_o(prio));
	ippc_core_model i_ippc_core_model (.clk_i(clk), .enter_o(ent), .exit_o(ext), .num_o(inum));
	// ====================
	// Tasks
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		samples_checked++;
		if (got !== ex) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// Read data and the error flag stand through the access cycle and are taken at its edge.
	task automatic apb(input bit wr, input [11:0] a, input [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		if (pready !== 1'h1) begin
			num_errors++;
			tally_and_finish;
		end else begin
			err = pslverr;
			rdat = prdata;
			psel <= 1'h0;
			penable <= 1'h0;
		end
	endtask
	task automatic rd_chk(input [11:0] a, input [31:0] ex);
		apb(1'h0, a, 32'h0);
		chk($sformatf("rd %h", a), ex, rdat);
	endtask
	task automatic irq_chk(input [5:0] n, input [1:0] p);
		repeat (2) @(posedge clk);
		chk("req", 32'(n != 6'h3f), 32'(req));
		chk("num", 32'(n), 32'(num));
		chk("prio", 32'(p), 32'(prio));
	endtask
	task automatic pulse(input int n);
		@(posedge clk);
		line[n] <= 1'h1;
		@(posedge clk);
		line[n] <= 1'h0;
		repeat (4) @(posedge clk);
	endtask
	task automatic fin_test(input string s);
		$display("test %s ended", s);
	endtask
	// ====================
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'h1;
		repeat (5) @(posedge clk);
		irq_chk(6'h3f, 2'h0);
		rd_chk(12'h100, 32'h0);
		rd_chk(12'h200, 32'h0);
		rd_chk(12'h41c, 32'h0);
		fin_test("reset");
		foreach (rows[i]) begin
			if (rows[i].wr)
				apb(1'h1, rows[i].a, rows[i].d);
			rd_chk(rows[i].a, rows[i].ex);
			chk("pslverr", 32'(rows[i].er), 32'(err));
		end
		fin_test("table");
		apb(1'h1, 12'h400, 32'h000040c0);
		apb(1'h1, 12'h180, 32'hffffffff);
		apb(1'h1, 12'h100, 32'h0b);
		apb(1'h1, 12'h200, 32'h0f);
		rd_chk(12'h200, 32'h0f);
		irq_chk(6'h3, 2'h0);
		apb(1'h1, 12'h100, 32'h04);
		irq_chk(6'h2, 2'h0);
		rd_chk(12'h304, 32'h00000102);
		apb(1'h1, 12'h280, 32'h0c);
		irq_chk(6'h1, 2'h1);
		apb(1'h1, 12'h280, 32'h02);
		irq_chk(6'h0, 2'h3);
		apb(1'h1, 12'h280, 32'h01);
		irq_chk(6'h3f, 2'h0);
		fin_test("priority");
		apb(1'h1, 12'h100, 32'h30);
		pulse(4);
		rd_chk(12'h200, 32'h10);
		i_ippc_core_model.strobe(1'h1, 6'h4);
		rd_chk(12'h200, 32'h0);
		rd_chk(12'h300, 32'h10);
		pulse(4);
		rd_chk(12'h200, 32'h10);
		i_ippc_core_model.strobe(1'h0, 6'h4);
		rd_chk(12'h300, 32'h0);
		rd_chk(12'h200, 32'h10);
		i_ippc_core_model.strobe(1'h1, 6'h4);
		pulse(4);
		apb(1'h1, 12'h280, 32'h10);
		rd_chk(12'h300, 32'h10);
		i_ippc_core_model.strobe(1'h0, 6'h4);
		rd_chk(12'h200, 32'h0);
		rd_chk(12'h300, 32'h0);
		fin_test("pulse");
		line[5] <= 1'h1;
		repeat (4) @(posedge clk);
		apb(1'h1, 12'h280, 32'h20);
		rd_chk(12'h200, 32'h20);
		i_ippc_core_model.strobe(1'h1, 6'h5);
		i_ippc_core_model.strobe(1'h0, 6'h5);
		rd_chk(12'h200, 32'h20);
		i_ippc_core_model.strobe(1'h1, 6'h5);
		line[5] <= 1'h0;
		repeat (4) @(posedge clk);
		i_ippc_core_model.strobe(1'h0, 6'h5);
		rd_chk(12'h200, 32'h0);
		apb(1'h1, 12'h200, 32'h20);
		apb(1'h1, 12'h280, 32'h20);
		rd_chk(12'h200, 32'h0);
		fin_test("level");
		apb(1'h1, 12'h200, 32'h20);
		irq_chk(6'h5, 2'h0);
		@(posedge clk);
		nrst <= 1'h0;
		repeat (2) @(posedge clk);
		nrst <= 1'h1;
		repeat (4) @(posedge clk);
		irq_chk(6'h3f, 2'h0);
		rd_chk(12'h100, 32'h0);
		rd_chk(12'h200, 32'h0);
		rd_chk(12'h400, 32'h0);
		fin_test("reset again");
		tally_and_finish;
	end
endmodule // test_interrupt_priority_pending_ctrl
